// ---- hdl/hssc_map.vh ----
`ifndef HSSC_MAP_VH
`define HSSC_MAP_VH
// Register addresses (7-bit)
`define HSSC_ADDR_SHUTDOWN 7'h10
`define HSSC_ADDR_SRC_A 7'h14
`define HSSC_ADDR_SRC_B 7'h15
`define HSSC_ADDR_PIN_CFG 7'h16
`define HSSC_ADDR_FIRST_PWM_GENERATOR_DUTY 7'h18
`define HSSC_ADDR_PWM_RATE 7'h1c
// Shutdown register fields
`define HSSC_SD_OV_BIT 6
`define HSSC_SD_UV_BIT 5
`define HSSC_SD_REC_BIT 4
`define HSSC_SD_MASK 8'h70
`define HSSC_SD_RESET 8'h00
// Switch source fields
`define HSSC_SRC_LO_MSB 2
`define HSSC_SRC_LO_LSB 0
`define HSSC_SRC_HI_MSB 6
`define HSSC_SRC_HI_LSB 4
`define HSSC_SRC_MASK 8'h77
`define HSSC_SRC_OFF 3'h0
`define HSSC_SRC_ON 3'h1
`define HSSC_SRC_TMR1 3'h2
`define HSSC_SRC_TMR2 3'h3
`define HSSC_SRC_FIRST_PWM_GENERATOR 3'h4
`define HSSC_SRC_SECOND_PWM_GENERATOR 3'h5
// Multipurpose pin fields
`define HSSC_PIN_DUTY_MSB 7
`define HSSC_PIN_DUTY_LSB 6
`define HSSC_PIN_TWO_MSB 5
`define HSSC_PIN_TWO_LSB 3
`define HSSC_PIN_ONE_MSB 2
`define HSSC_PIN_ONE_LSB 0
`define HSSC_PIN_OFF 3'h4
`define HSSC_PIN_WAKE 3'h5
`define HSSC_PIN_LOW_ON 3'h6
`define HSSC_PIN_HIGH_ON 3'h7
// Rate register fields
`define HSSC_RATE_FIRST_PWM_GENERATOR_BIT 0
`define HSSC_RATE_SECOND_PWM_GENERATOR_BIT 2
`define HSSC_RATE_MASK 8'h05
// Reset and full-duty values
`define HSSC_ZERO8 8'h00
`define HSSC_DUTY_FULL 8'hff
// Timing
`define HSSC_CLK_HZ 25000000
`define HSSC_PWM_SLOW_HZ 200
`define HSSC_PWM_FAST_HZ 400
`define HSSC_PWM_STEPS 255
`define HSSC_WAKE_FILT_NS 16000
`define HSSC_CLK_NS 40
`define HSSC_FAIL_PERIOD_HZ 100
// Fail output phases and on lengths
`define HSSC_FAIL_PHASES 40
`define HSSC_FAIL_LAST_PHASE 6'h27
`define HSSC_FO_ON_20 6'h08
`define HSSC_FO_ON_10 6'h04
`define HSSC_FO_ON_5 6'h02
`define HSSC_FO_ON_2P5 6'h01
// Last PWM step of a period
`define HSSC_PWM_LAST_STEP 8'hfe
`endif

// ---- hdl/hssc_pwm.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hssc_map.vh"
module hssc_pwm #(
  parameter PRESCALE = `HSSC_CLK_HZ / (`HSSC_PWM_SLOW_HZ * `HSSC_PWM_STEPS)
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Control
  input wire [7:0] duty_in,
  input wire fast_in,
  // Output
  output reg pwm_out
);
  reg [15:0] pre;
  reg [7:0] step;
  wire [15:0] pre_lim;
  assign pre_lim = fast_in ? (PRESCALE[15:0] >> 1) : PRESCALE[15:0];
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pre <= 16'h0000;
      step <= 8'h00;
      pwm_out <= 1'b0;
    end else begin
      if (pre + 16'h0001 >= pre_lim) begin
        pre <= 16'h0000;
        step <= (step == `HSSC_PWM_LAST_STEP) ? 8'h00 : step + 8'h01;
      end else begin
        pre <= pre + 16'h0001;
      end
      // Zero always off, full always on
      if (duty_in == `HSSC_ZERO8)
        pwm_out <= 1'b0; // [RULE_13]
      else if (duty_in == `HSSC_DUTY_FULL)
        pwm_out <= 1'b1;
      else
        pwm_out <= (step < duty_in); // [RULE_13]
    end
  end
endmodule
`default_nettype wire

// ---- hdl/hssc_pin.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hssc_map.vh"
module hssc_pin #(
  parameter FILT_CYC = (`HSSC_WAKE_FILT_NS + `HSSC_CLK_NS - 1) / `HSSC_CLK_NS,
  parameter FAIL_PER = `HSSC_CLK_HZ / `HSSC_FAIL_PERIOD_HZ / `HSSC_FAIL_PHASES
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Configuration
  input wire [2:0] mode_in,
  input wire [1:0] duty_in,
  input wire fail_in,
  // Pin
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe_out,
  output reg wake_out
);
  reg [9:0] filt;
  reg [15:0] pre;
  reg [5:0] phase;
  reg [5:0] on_len;
  always @* begin
    case (duty_in)
      2'h0: on_len = `HSSC_FO_ON_20;
      2'h1: on_len = `HSSC_FO_ON_10;
      2'h2: on_len = `HSSC_FO_ON_5;
      default: on_len = `HSSC_FO_ON_2P5;
    endcase
  end
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      filt <= 10'h000;
      pre <= 16'h0000;
      phase <= 6'h00;
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      if (pre + 16'h0001 >= FAIL_PER[15:0]) begin
        pre <= 16'h0000;
        phase <= (phase == `HSSC_FAIL_LAST_PHASE) ? 6'h00 : phase + 6'h01;
      end else begin
        pre <= pre + 16'h0001;
      end
      // Static wake filter
      if (mode_in == `HSSC_PIN_WAKE && pin_in != wake_out) begin
        if (filt + 10'h001 >= FILT_CYC[9:0]) begin
          wake_out <= pin_in; // [RULE_11] [RULE_12]
          filt <= 10'h000;
        end else begin
          filt <= filt + 10'h001;
        end
      end else begin
        filt <= 10'h000;
      end
      case (mode_in)
        `HSSC_PIN_OFF, `HSSC_PIN_WAKE: begin
          pin_out <= 1'b0;
          pin_oe_out <= 1'b0;
        end
        `HSSC_PIN_LOW_ON: begin
          pin_out <= 1'b0;
          pin_oe_out <= 1'b1;
        end
        `HSSC_PIN_HIGH_ON: begin
          pin_out <= 1'b1;
          pin_oe_out <= 1'b1;
        end
        default: begin
          // Fail output, pulsed at duty of 40 phases
          pin_out <= fail_in & (phase < on_len); // [RULE_10]
          pin_oe_out <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hdl/hssc_top.v ----
// Operation
// [RULE_01] Bit 6 clear: supply overvoltage switches all four off; set: ignored.
// [RULE_02] Bit 5 clear: supply undervoltage switches all four off; set: ignored.
// [RULE_03] Bit 4 set: switches restore prior state after fault clears; else off.
// [RULE_04] Reserved bits always read zero.
// [RULE_05] Shutdown register zero on reset; restart keeps bits 6 to 4.
// [RULE_06] Switch one source bits 2:0: off, on, timers, PWMs; 110/111 reserved.
// [RULE_07] Switch two source bits 6:4, same encoding.
// [RULE_08] Second register holds switches three and four, same encoding.
// [RULE_09] Overcurrent or overtemperature clears that switch's field to off.
// [RULE_10] Fail output duty: 20, 10, 5 or 2.5 percent.
// [RULE_11] Pin two field: fail three, off, wake, low-side on, high-side on.
// [RULE_12] Pin one field: fail two, off, wake, low-side on, high-side on.
// [RULE_13] PWM one duty: 0 off, 255 on, else N/255.
// [RULE_14] Controller must not expect tiny duty values to produce output.
// [RULE_15] PWM one duty zero on reset, kept through restart.
// [RULE_16] Controller assigns the matching timer when selecting cyclic filter.
// [RULE_17] Assigned timer starts once its on-time is written running.
// [RULE_18] PWM runs 200Hz with rate bit 0, 400Hz with bit 1.
// [RULE_19] Reserved source codes keep the switch off.
`timescale 1ns/1ps
`default_nettype none
`include "hssc_map.vh"
module hssc_top (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  input wire soft_rst_in,
  input wire restart_in,
  // Register access
  input wire wr_en_in,
  input wire [6:0] addr_in,
  input wire [7:0] wr_data_in,
  output reg [7:0] rd_data_out,
  // Supply and switch faults
  input wire supply_ov_in,
  input wire supply_uv_in,
  input wire [3:0] sw_fault_in,
  // Timer, second PWM and fail sources
  input wire first_cyclic_timer_in,
  input wire second_cyclic_timer_in,
  input wire [7:0] second_pwm_duty_in,
  input wire fail_two_in,
  input wire fail_three_in,
  // Switch outputs
  output reg [3:0] switch_out,
  // Multipurpose pins
  input wire pin_one_in,
  output wire pin_one_out,
  output wire pin_one_oe_out,
  output wire wake_one_out,
  input wire pin_two_in,
  output wire pin_two_out,
  output wire pin_two_oe_out,
  output wire wake_two_out
);
  reg [7:0] shutdown;
  reg [7:0] src_a;
  reg [7:0] src_b;
  reg [7:0] pin_cfg;
  reg [7:0] first_pwm_generator_duty;
  reg [7:0] pwm_rate;
  reg [3:0] held;
  reg fault_latched;
  reg [7:0] next_src_a;
  reg [7:0] next_src_b;
  wire first_pwm_generator;
  wire second_pwm_generator;
  wire cut_ov;
  wire cut_uv;
  wire cut;
  wire [2:0] fld [0:3];
  wire [3:0] drive;
  reg stay_off;
  wire src_write;

  function src_level;
    input [2:0] code;
    input t1;
    input t2;
    input p1;
    input p2;
    begin
      case (code)
        `HSSC_SRC_OFF: src_level = 1'b0; // [RULE_06]
        `HSSC_SRC_ON: src_level = 1'b1;
        `HSSC_SRC_TMR1: src_level = t1; // [RULE_17]
        `HSSC_SRC_TMR2: src_level = t2;
        `HSSC_SRC_FIRST_PWM_GENERATOR: src_level = p1;
        `HSSC_SRC_SECOND_PWM_GENERATOR: src_level = p2;
        default: src_level = 1'b0; // [RULE_19]
      endcase
    end
  endfunction

  // Write strobe aimed at one register
  function wr_hit;
    input en;
    input [6:0] addr;
    input [6:0] target;
    begin
      wr_hit = en && (addr == target);
    end
  endfunction

  assign fld[0] = src_a[`HSSC_SRC_LO_MSB:`HSSC_SRC_LO_LSB]; // [RULE_06]
  assign fld[1] = src_a[`HSSC_SRC_HI_MSB:`HSSC_SRC_HI_LSB]; // [RULE_07]
  assign fld[2] = src_b[`HSSC_SRC_LO_MSB:`HSSC_SRC_LO_LSB]; // [RULE_08]
  assign fld[3] = src_b[`HSSC_SRC_HI_MSB:`HSSC_SRC_HI_LSB]; // [RULE_08]

  assign cut_ov = supply_ov_in & ~shutdown[`HSSC_SD_OV_BIT]; // [RULE_01]
  assign cut_uv = supply_uv_in & ~shutdown[`HSSC_SD_UV_BIT]; // [RULE_02]
  assign cut = cut_ov | cut_uv;
  assign src_write = wr_hit(wr_en_in, addr_in, `HSSC_ADDR_SRC_A) | wr_hit(wr_en_in, addr_in, `HSSC_ADDR_SRC_B);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sw
      assign drive[g] = src_level(fld[g], first_cyclic_timer_in, second_cyclic_timer_in, first_pwm_generator, second_pwm_generator);
    end
  endgenerate

  // Register writes with hardware clear of faulted switches
  always @* begin
    next_src_a = src_a;
    next_src_b = src_b;
    if (wr_hit(wr_en_in, addr_in, `HSSC_ADDR_SRC_A))
      next_src_a = wr_data_in & `HSSC_SRC_MASK; // [RULE_04]
    if (wr_hit(wr_en_in, addr_in, `HSSC_ADDR_SRC_B))
      next_src_b = wr_data_in & `HSSC_SRC_MASK;
    if (sw_fault_in[0])
      next_src_a[`HSSC_SRC_LO_MSB:`HSSC_SRC_LO_LSB] = `HSSC_SRC_OFF; // [RULE_09]
    if (sw_fault_in[1])
      next_src_a[`HSSC_SRC_HI_MSB:`HSSC_SRC_HI_LSB] = `HSSC_SRC_OFF; // [RULE_09]
    if (sw_fault_in[2])
      next_src_b[`HSSC_SRC_LO_MSB:`HSSC_SRC_LO_LSB] = `HSSC_SRC_OFF;
    if (sw_fault_in[3])
      next_src_b[`HSSC_SRC_HI_MSB:`HSSC_SRC_HI_LSB] = `HSSC_SRC_OFF;
  end

  always @(posedge ref_clk_in) begin
    if (rst_in || soft_rst_in) begin
      shutdown <= `HSSC_SD_RESET; // [RULE_05]
      src_a <= `HSSC_ZERO8;
      src_b <= `HSSC_ZERO8;
      pin_cfg <= `HSSC_ZERO8;
      first_pwm_generator_duty <= `HSSC_ZERO8; // [RULE_15]
      pwm_rate <= `HSSC_ZERO8;
    end else if (restart_in) begin
      shutdown <= shutdown & `HSSC_SD_MASK; // [RULE_05]
      src_a <= `HSSC_ZERO8;
      src_b <= `HSSC_ZERO8;
      pwm_rate <= pwm_rate & `HSSC_RATE_MASK;
      // Duty held through restart [RULE_15]
    end else begin
      src_a <= next_src_a;
      src_b <= next_src_b;
      if (wr_en_in) begin
        case (addr_in)
          `HSSC_ADDR_SHUTDOWN: shutdown <= wr_data_in & `HSSC_SD_MASK; // [RULE_04]
          `HSSC_ADDR_PIN_CFG: pin_cfg <= wr_data_in;
          `HSSC_ADDR_FIRST_PWM_GENERATOR_DUTY: first_pwm_generator_duty <= wr_data_in;
          `HSSC_ADDR_PWM_RATE: pwm_rate <= wr_data_in & `HSSC_RATE_MASK;
          default: pwm_rate <= pwm_rate;
        endcase
      end
    end
  end

  // Supply fault shutdown and recovery
  always @(posedge ref_clk_in) begin
    if (rst_in || soft_rst_in || restart_in) begin
      fault_latched <= 1'b0;
      held <= 4'h0;
      stay_off <= 1'b0;
      switch_out <= 4'h0;
    end else if (cut) begin
      if (!fault_latched)
        held <= drive;
      fault_latched <= 1'b1;
      switch_out <= 4'h0; // [RULE_01] [RULE_02]
    end else if (fault_latched) begin
      fault_latched <= 1'b0;
      stay_off <= ~shutdown[`HSSC_SD_REC_BIT]; // [RULE_03]
      switch_out <= shutdown[`HSSC_SD_REC_BIT] ? (held & ~sw_fault_in) : 4'h0; // [RULE_03]
    end else if (stay_off) begin
      // Without recovery the switches stay off until reconfigured
      if (src_write)
        stay_off <= 1'b0;
      switch_out <= 4'h0; // [RULE_03]
    end else begin
      switch_out <= drive & ~sw_fault_in;
    end
  end

  hssc_pwm u_first_pwm_generator (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .duty_in(first_pwm_generator_duty),
    .fast_in(pwm_rate[`HSSC_RATE_FIRST_PWM_GENERATOR_BIT]), // [RULE_18]
    .pwm_out(first_pwm_generator)
  );

  hssc_pwm u_second_pwm_generator (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .duty_in(second_pwm_duty_in),
    .fast_in(pwm_rate[`HSSC_RATE_SECOND_PWM_GENERATOR_BIT]), // [RULE_18]
    .pwm_out(second_pwm_generator)
  );

  hssc_pin u_pin_one (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .mode_in(pin_cfg[`HSSC_PIN_ONE_MSB:`HSSC_PIN_ONE_LSB]), // [RULE_12]
    .duty_in(pin_cfg[`HSSC_PIN_DUTY_MSB:`HSSC_PIN_DUTY_LSB]),
    .fail_in(fail_two_in),
    .pin_in(pin_one_in),
    .pin_out(pin_one_out),
    .pin_oe_out(pin_one_oe_out),
    .wake_out(wake_one_out)
  );

  hssc_pin u_pin_two (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .mode_in(pin_cfg[`HSSC_PIN_TWO_MSB:`HSSC_PIN_TWO_LSB]), // [RULE_11]
    .duty_in(pin_cfg[`HSSC_PIN_DUTY_MSB:`HSSC_PIN_DUTY_LSB]), // [RULE_10]
    .fail_in(fail_three_in),
    .pin_in(pin_two_in),
    .pin_out(pin_two_out),
    .pin_oe_out(pin_two_oe_out),
    .wake_out(wake_two_out)
  );

  // Read back, reserved bits zero
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_data_out <= `HSSC_ZERO8;
    end else begin
      case (addr_in)
        `HSSC_ADDR_SHUTDOWN: rd_data_out <= shutdown; // [RULE_04]
        `HSSC_ADDR_SRC_A: rd_data_out <= src_a;
        `HSSC_ADDR_SRC_B: rd_data_out <= src_b;
        `HSSC_ADDR_PIN_CFG: rd_data_out <= pin_cfg;
        `HSSC_ADDR_FIRST_PWM_GENERATOR_DUTY: rd_data_out <= first_pwm_generator_duty;
        `HSSC_ADDR_PWM_RATE: rd_data_out <= pwm_rate;
        default: rd_data_out <= `HSSC_ZERO8;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- test/hssc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module hssc_monitor (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  input wire soft_rst_in,
  // Register access
  input wire wr_en_in,
  input wire [6:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire [7:0] rd_data_out,
  // Supply and switches
  input wire supply_ov_in,
  input wire supply_uv_in,
  input wire [3:0] sw_fault_in,
  input wire [3:0] switch_out
);
  // Shadow of shutdown bits 6 to 4
  logic [2:0] sd;
  always @(posedge ref_clk_in) begin
    if (rst_in || soft_rst_in) sd <= 3'h0;
    else if (wr_en_in && addr_in == 7'h10) sd <= wr_data_in[6:4];
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_ov; supply_ov_in && !sd[2] |=> switch_out == 4'h0; endproperty
  a_ov: assert property (p_ov) else $error("switch on in overvoltage");
  property p_uv; supply_uv_in && !sd[1] |=> switch_out == 4'h0; endproperty
  a_uv: assert property (p_uv) else $error("switch on in undervoltage");
  property p_fault; |sw_fault_in |-> ##2 (switch_out & $past(sw_fault_in, 2)) == 4'h0; endproperty
  a_fault: assert property (p_fault) else $error("faulted switch still on");
  property p_sd; addr_in == 7'h10 |=> rd_data_out == {1'b0, $past(sd), 4'h0}; endproperty
  a_sd: assert property (p_sd) else $error("shutdown readback wrong");
  property p_src; addr_in == 7'h14 || addr_in == 7'h15 |=> (rd_data_out & 8'h88) == 8'h00; endproperty
  a_src: assert property (p_src) else $error("source reserved bit set");
  property p_rate; addr_in == 7'h1c |=> (rd_data_out & 8'hfa) == 8'h00; endproperty
  a_rate: assert property (p_rate) else $error("rate reserved bit set");
  property p_soft; soft_rst_in ##1 addr_in == 7'h18 |=> rd_data_out == 8'h00; endproperty
  a_soft: assert property (p_soft) else $error("duty kept over soft reset");
  property p_rst; disable iff (1'b0) rst_in |=> rd_data_out == 8'h00 && switch_out == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ---- test/hssc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module hssc_host (
  // Clock and read data
  input wire logic ref_clk_in,
  input wire logic [7:0] rd_data_in,
  // Register access
  output logic wr_en_out = 1'b0,
  output logic [6:0] addr_out = 7'h00,
  output logic [7:0] wr_data_out = 8'h00
);
  // Only full-off or full-on duty is relied upon
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    wr_en_out = 1'b1;
    addr_out = a;
    wr_data_out = d;
    @(posedge ref_clk_in);
    #1;
    wr_en_out = 1'b0;
    wr_data_out = ~d;
  endtask
  // No cyclic filter is configured
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    addr_out = a;
    @(posedge ref_clk_in);
    #1;
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// ---- test/hssc_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module hssc_top_bench;
  logic ref_clk_in = 0, rst_in = 1, soft_rst_in = 0, restart_in = 0;
  logic supply_ov_in = 0, supply_uv_in = 0, first_cyclic_timer_in = 0, second_cyclic_timer_in = 0;
  logic fail_two_in = 0, fail_three_in = 0, pin_one_in = 0, pin_two_in = 0;
  logic [3:0] sw_fault_in = 0;
  logic [7:0] second_pwm_duty_in = 0, v;
  wire wr_en_in, pin_one_out, pin_one_oe_out, wake_one_out, pin_two_out, pin_two_oe_out, wake_two_out;
  wire [6:0] addr_in;
  wire [7:0] wr_data_in, rd_data_out;
  wire [3:0] switch_out;
  int fails = 0, num_checks = 0, cyc = 0, seed;
  logic [6:0] addrs [7] = '{7'h10, 7'h14, 7'h15, 7'h16, 7'h18, 7'h1c, 7'h01};
  logic [2:0] pm [3] = '{3'h4, 3'h6, 3'h7};
  logic [7:0] pe [3] = '{8'h00, 8'h02, 8'h03};
  initial forever #20 ref_clk_in = ~ref_clk_in;
  hssc_top hssc_top_i (.ref_clk_in, .rst_in, .soft_rst_in, .restart_in, .wr_en_in, .addr_in, .wr_data_in,
    .rd_data_out, .supply_ov_in, .supply_uv_in, .sw_fault_in, .first_cyclic_timer_in, .second_cyclic_timer_in,
    .second_pwm_duty_in, .fail_two_in, .fail_three_in, .switch_out, .pin_one_in, .pin_one_out, .pin_one_oe_out,
    .wake_one_out, .pin_two_in, .pin_two_out, .pin_two_oe_out, .wake_two_out);
  hssc_host hssc_host_i (.ref_clk_in, .rd_data_in(rd_data_out), .wr_en_out(wr_en_in), .addr_out(addr_in),
    .wr_data_out(wr_data_in));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    hssc_host_i.rd(a, v);
    chk("register", v, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  function automatic logic [7:0] mask(input logic [6:0] a);
    case (a)
      7'h10: mask = 8'h70;
      7'h14, 7'h15: mask = 8'h77;
      7'h16, 7'h18: mask = 8'hff;
      7'h1c: mask = 8'h05;
      default: mask = 8'h00;
    endcase
  endfunction
  function automatic logic exp_sw(input logic [2:0] c, input logic ph);
    exp_sw = (c == 3'h1) || ((c inside {3'h2, 3'h4}) && !ph) || ((c inside {3'h3, 3'h5}) && ph);
  endfunction
  initial begin
    seed = $urandom(74);
    wt(8);
    rst_in = 0;
    wt(1);
    foreach (addrs[i]) rchk(addrs[i], 8'h00);
    for (int k = 0; k < 4; k++)
      foreach (addrs[i]) begin
        v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
        hssc_host_i.wr(addrs[i], v);
        rchk(addrs[i], v & mask(addrs[i]));
      end
    hssc_host_i.wr(7'h1c, 8'h01);
    for (int ph = 0; ph < 2; ph++)
      for (int c = 0; c < 8; c++) begin
        {first_cyclic_timer_in, second_cyclic_timer_in} = ph ? 2'b01 : 2'b10;
        second_pwm_duty_in = ph ? 8'hff : 8'h00;
        hssc_host_i.wr(7'h18, ph ? 8'h00 : 8'hff);
        hssc_host_i.wr(7'h14, {1'b0, c[2:0], 1'b0, c[2:0]});
        hssc_host_i.wr(7'h15, {1'b0, c[2:0], 1'b0, c[2:0]});
        wt(1100);
        chk("switch", {4'h0, switch_out}, {4'h0, {4{exp_sw(c[2:0], ph[0])}}});
      end
    hssc_host_i.wr(7'h14, 8'h11);
    sw_fault_in = 4'h1;
    wt(1);
    sw_fault_in = 4'h0;
    rchk(7'h14, 8'h10);
    for (int k = 0; k < 4; k++) begin
      hssc_host_i.wr(7'h10, k[1] ? 8'h60 : 8'h00);
      hssc_host_i.wr(7'h14, 8'h11);
      hssc_host_i.wr(7'h15, 8'h11);
      {supply_ov_in, supply_uv_in} = k[0] ? 2'b01 : 2'b10;
      wt(2);
      chk("supply cut", {4'h0, switch_out}, k[1] ? 8'h0f : 8'h00);
      {supply_ov_in, supply_uv_in} = 2'b00;
      wt(2);
      chk("stay off", {4'h0, switch_out}, k[1] ? 8'h0f : 8'h00);
    end
    hssc_host_i.wr(7'h10, 8'h10);
    supply_ov_in = 1;
    wt(2);
    supply_ov_in = 0;
    wt(2);
    chk("recovery", {4'h0, switch_out}, 8'h0f);
    hssc_host_i.wr(7'h10, 8'h70);
    hssc_host_i.wr(7'h18, 8'h5a);
    restart_in = 1;
    wt(1);
    restart_in = 0;
    rchk(7'h10, 8'h70);
    rchk(7'h14, 8'h00);
    rchk(7'h18, 8'h5a);
    soft_rst_in = 1;
    wt(1);
    soft_rst_in = 0;
    rchk(7'h18, 8'h00);
    rchk(7'h10, 8'h00);
    foreach (pm[i]) begin
      hssc_host_i.wr(7'h16, {2'b00, pm[i], pm[i]});
      wt(4);
      chk("pin one", {6'h0, pin_one_oe_out, pin_one_out & pin_one_oe_out}, pe[i]);
      chk("pin two", {6'h0, pin_two_oe_out, pin_two_out & pin_two_oe_out}, pe[i]);
    end
    hssc_host_i.wr(7'h16, 8'h2d);
    {pin_one_in, pin_two_in} = 2'b11;
    wt(500);
    chk("wake", {6'h0, wake_one_out, wake_two_out}, 8'h03);
    hssc_host_i.wr(7'h16, 8'h00);
    fail_two_in = 1;
    wt(2);
    chk("fail two", {6'h0, pin_one_oe_out, pin_one_out}, 8'h03);
    chk("fail three", {6'h0, pin_two_oe_out, pin_two_out}, 8'h02);
    hssc_host_i.wr(7'h16, 8'hc0);
    wt(2);
    chk("fail duty", {6'h0, pin_one_oe_out, pin_one_out}, 8'h02);
    print_verdict;
  end
endmodule
bind hssc_top hssc_monitor hssc_monitor_i (.ref_clk_in, .rst_in, .soft_rst_in, .wr_en_in, .addr_in, .wr_data_in,
  .rd_data_out, .supply_ov_in, .supply_uv_in, .sw_fault_in, .switch_out);
`default_nettype wire
